// ---- pkg/idc_map.vh ----
`ifndef IDC_MAP_VH
`define IDC_MAP_VH
`define IDC_ADDR_W 16
`define IDC_OFS_STATE 16'h0002
`define IDC_OFS_SELECT 16'h9400
`define IDC_OFS_CONFIG 16'h0001
`define IDC_OFS_SLEEP_STAT 16'h9401
`define IDC_CFG_CORE 0
`define IDC_CFG_MASTER 1
`define IDC_CFG_CACHE 2
`define IDC_CFG_DEVICE_BLOCK_IDLE_ENABLE 3
`define IDC_CFG_CLKGEN 4
`define IDC_CFG_EXT_MEM_IFACE_SLEEP 5
`define IDC_CFG_XPORT 6
`define IDC_CFG_MPORT 7
`define IDC_CFG_IPORT 8
`define IDC_CFG_CLKCOMP 9
`define IDC_CFG_MASK 16'h03FF
`define IDC_CLK_NEED_MASK 16'h03F7
`define IDC_SEL_MASK 16'h3FFF
`define IDC_STATE_MASK 16'h01FF
`define IDC_RESET_VAL 16'h0000
`define IDC_STOP_CYCLES 4'h2
`endif

// ---- rtl/idc_stop_seq.v ----
`timescale 1ns/1ps
`default_nettype none
// per-domain stop/wake handshake: flag sets on ack while requested, holds until request drops
module idc_stop_seq #(
  parameter N = 10
) (
  input wire clk,
  input wire rst_n,
  input wire [N-1:0] stop_req,
  input wire [N-1:0] stop_ack,
  output reg [N-1:0] stopped_reg
);
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_dom
      always @(posedge clk) begin
        if (!rst_n) begin
          stopped_reg[i] <= 1'b0;
        end else if (stop_req[i] && stop_ack[i]) begin
          stopped_reg[i] <= 1'b1;
        end else if (!stop_req[i]) begin
          stopped_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- rtl/idc_top.v ----
// Operation
// - peripheral idle off: idle wakes all peripherals
// - peripheral idle on: stop selected peripherals
// - cache idle bit stops instruction cache
// - master idle bit stops dma and host port
// - core idle bit stops core
// - status shows fetch, master, io ports
// - status shows ext memory and clock gen
// - status bit 3 shows peripheral group idle
// - select 13 stops miscellaneous register group
// - select 12 stops ext memory interface
// - select 11,10 stop tick and watchdog timers
// - select 9,8,7 stop pins, serial, i2c
// - flag cleared then idle wakes all peripherals
// - flag set: idle wakes unselected peripherals
// - bad clock idle combination raises bus error
// - select 6..0 stop their peripherals
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "idc_map.vh"
module idc_top #(
  parameter NSEL = 14
) (
  input wire clk,
  input wire rst_n,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata_reg,
  input wire idle_exec,
  input wire [9:0] dom_ack_async,
  input wire [NSEL-1:0] per_ack_async,
  output reg [9:0] dom_stop_reg,
  output reg [NSEL-1:0] per_stop_reg,
  output reg bus_error_reg
);
  reg [15:0] cfg_reg;
  reg [NSEL-1:0] sel_reg;
  reg [2:0] grp_state_reg;
  reg [2:0] grp_state_next;
  reg [3:0] rd_sel;
  reg [9:0] dom_ack_s1_reg;
  reg [9:0] dom_ack_s2_reg;
  reg [NSEL-1:0] per_ack_s1_reg;
  reg [NSEL-1:0] per_ack_s2_reg;
  reg [NSEL-1:0] per_done_reg;
  wire [9:0] dom_stopped;
  wire clk_bad;
  wire [15:0] state_val;
  reg [15:0] rd_next;
  wire idle_go;
  wire [NSEL-1:0] per_stop_next;
  genvar g;

  // peripheral group: awake, asleep waiting for ack, down
  localparam [2:0] GRP_AWAKE = 3'b001;
  localparam [2:0] GRP_ASLEEP = 3'b010;
  localparam [2:0] GRP_DOWN = 3'b100;

  function hit;
    input [15:0] a;
    input [15:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  function [3:0] rd_decode;
    input [15:0] a;
    begin
      rd_decode = 4'h0;
      if (hit(a, `IDC_OFS_STATE)) begin
        rd_decode = 4'h1;
      end
      if (hit(a, `IDC_OFS_SELECT)) begin
        rd_decode = 4'h2;
      end
      if (hit(a, `IDC_OFS_CONFIG)) begin
        rd_decode = 4'h4;
      end
      if (hit(a, `IDC_OFS_SLEEP_STAT)) begin
        rd_decode = 4'h8;
      end
    end
  endfunction

  // clock gen idle needs companion and every domain but the group
  function clk_combo_bad;
    input [15:0] c;
    begin
      clk_combo_bad = c[`IDC_CFG_CLKGEN] &&
        ((c & `IDC_CLK_NEED_MASK) != `IDC_CLK_NEED_MASK);
    end
  endfunction

  function [15:0] status_word;
    input [9:0] stopped;
    input grp_down;
    begin
      status_word = 16'h0000;
      status_word[8] = stopped[`IDC_CFG_IPORT];
      status_word[7] = stopped[`IDC_CFG_MPORT];
      status_word[6] = stopped[`IDC_CFG_XPORT];
      status_word[5] = stopped[`IDC_CFG_EXT_MEM_IFACE_SLEEP];
      status_word[4] = stopped[`IDC_CFG_CLKGEN];
      status_word[3] = grp_down;
      status_word[2] = stopped[`IDC_CFG_CACHE];
      status_word[1] = stopped[`IDC_CFG_MASTER];
      status_word[0] = stopped[`IDC_CFG_CORE];
    end
  endfunction

  assign clk_bad = clk_combo_bad(cfg_reg);
  assign idle_go = idle_exec && !clk_bad;

  // two-stage synchronisers for domain acks
  generate
    for (g = 0; g < 10; g = g + 1) begin : g_dom_sync
      always @(posedge clk) begin
        if (!rst_n) begin
          dom_ack_s1_reg[g] <= 1'b0;
          dom_ack_s2_reg[g] <= 1'b0;
        end else begin
          dom_ack_s1_reg[g] <= dom_ack_async[g];
          dom_ack_s2_reg[g] <= dom_ack_s1_reg[g];
        end
      end
    end
  endgenerate

  // two-stage synchronisers for peripheral acks
  generate
    for (g = 0; g < NSEL; g = g + 1) begin : g_per_sync
      always @(posedge clk) begin
        if (!rst_n) begin
          per_ack_s1_reg[g] <= 1'b0;
          per_ack_s2_reg[g] <= 1'b0;
        end else begin
          per_ack_s1_reg[g] <= per_ack_async[g];
          per_ack_s2_reg[g] <= per_ack_s1_reg[g];
        end
      end
    end
  endgenerate

  // register writes; reserved bits dropped
  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_reg <= `IDC_RESET_VAL;
      sel_reg <= {NSEL{1'b0}};
    end else if (wr) begin
      if (hit(addr, `IDC_OFS_CONFIG)) begin
        cfg_reg <= wdata & `IDC_CFG_MASK;
      end
      if (hit(addr, `IDC_OFS_SELECT)) begin
        sel_reg <= wdata[NSEL-1:0];
      end
    end
  end

  // illegal clock idle pulses the error and changes nothing
  always @(posedge clk) begin
    if (!rst_n) begin
      bus_error_reg <= 1'b0;
    end else begin
      bus_error_reg <= idle_exec && clk_bad;
    end
  end

  // domain stops latched on idle, one per config bit
  generate
    for (g = 0; g < 10; g = g + 1) begin : g_dom_stop
      always @(posedge clk) begin
        if (!rst_n) begin
          dom_stop_reg[g] <= 1'b0;
        end else if (idle_go) begin
          dom_stop_reg[g] <= cfg_reg[g];
        end
      end
    end
  endgenerate

  // group idle on loads select, off wakes all
  generate
    for (g = 0; g < NSEL; g = g + 1) begin : g_per_stop
      assign per_stop_next[g] = cfg_reg[`IDC_CFG_DEVICE_BLOCK_IDLE_ENABLE] ? sel_reg[g] : 1'b0;
      always @(posedge clk) begin
        if (!rst_n) begin
          per_stop_reg[g] <= 1'b0;
          per_done_reg[g] <= 1'b0;
        end else begin
          if (idle_go) begin
            per_stop_reg[g] <= per_stop_next[g];
          end
          per_done_reg[g] <= per_stop_reg[g] & per_ack_s2_reg[g];
        end
      end
    end
  endgenerate

  // group flag follows the group's stop acknowledge
  always @* begin
    grp_state_next = grp_state_reg;
    case (grp_state_reg)
      GRP_AWAKE: begin
        if (idle_go && cfg_reg[`IDC_CFG_DEVICE_BLOCK_IDLE_ENABLE]) begin
          grp_state_next = GRP_ASLEEP;
        end
      end
      GRP_ASLEEP: begin
        if (idle_go && !cfg_reg[`IDC_CFG_DEVICE_BLOCK_IDLE_ENABLE]) begin
          grp_state_next = GRP_AWAKE;
        end else if (dom_stopped[`IDC_CFG_DEVICE_BLOCK_IDLE_ENABLE]) begin
          grp_state_next = GRP_DOWN;
        end
      end
      GRP_DOWN: begin
        if (idle_go && !cfg_reg[`IDC_CFG_DEVICE_BLOCK_IDLE_ENABLE]) begin
          grp_state_next = GRP_AWAKE;
        end else if (!dom_stopped[`IDC_CFG_DEVICE_BLOCK_IDLE_ENABLE]) begin
          grp_state_next = GRP_ASLEEP;
        end
      end
      default: begin
        grp_state_next = GRP_AWAKE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      grp_state_reg <= GRP_AWAKE;
    end else begin
      grp_state_reg <= grp_state_next;
    end
  end

  idc_stop_seq #(
    .N(10)
  ) u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .stop_req(dom_stop_reg),
    .stop_ack(dom_ack_s2_reg),
    .stopped_reg(dom_stopped)
  );

  // status: bit3 is the group down state
  assign state_val = status_word(dom_stopped, grp_state_reg == GRP_DOWN);

  always @* begin
    rd_next = 16'h0000;
    rd_sel = rd_decode(addr);
    case (rd_sel)
      4'h1: begin
        rd_next = state_val & `IDC_STATE_MASK;
      end
      4'h2: begin
        rd_next = {{(16-NSEL){1'b0}}, sel_reg};
      end
      4'h4: begin
        rd_next = cfg_reg;
      end
      4'h8: begin
        rd_next = {{(16-NSEL){1'b0}}, per_done_reg};
      end
      default: begin
        rd_next = 16'h0000;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (rd) begin
      rdata_reg <= rd_next;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- bench/idc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module idc_monitor #(parameter NSEL = 14) (
  input wire logic clk, rst_n, rd, idle_exec, bus_error_reg,
  input wire logic [15:0] addr, rdata_reg,
  input wire logic [9:0] dom_stop_reg,
  input wire logic [NSEL-1:0] per_stop_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_a; bus_error_reg |=> !bus_error_reg; endproperty
  a_a: assert property (p_a) else $error("long error");
  property p_b; bus_error_reg |-> $past(idle_exec); endproperty
  a_b: assert property (p_b) else $error("stray error");
  property p_c; !idle_exec |=> $stable(dom_stop_reg); endproperty
  a_c: assert property (p_c) else $error("dom moved");
  property p_d; !idle_exec |=> $stable(per_stop_reg); endproperty
  a_d: assert property (p_d) else $error("per moved");
  property p_e; bus_error_reg |-> $stable(dom_stop_reg) && $stable(per_stop_reg); endproperty
  a_e: assert property (p_e) else $error("error idled");
  property p_f; rd && addr == 16'h0002 |=> rdata_reg[15:9] == 7'h00; endproperty
  a_f: assert property (p_f) else $error("status rsvd");
  property p_g; rd && addr == 16'h9400 |=> rdata_reg[15:14] == 2'h0; endproperty
  a_g: assert property (p_g) else $error("select rsvd");
  property p_h; idle_exec ##1 (!bus_error_reg && !dom_stop_reg[3]) |-> per_stop_reg == 0;
  endproperty
  a_h: assert property (p_h) else $error("no wake");
  cover property (bus_error_reg);
  cover property (idle_exec ##1 per_stop_reg != 0);
  cover property (rd ##1 rdata_reg != 0);
endmodule
bind idc_top idc_monitor #(.NSEL(NSEL)) u_mon(.*);
`default_nettype wire

// ---- bench/test_idle_domain_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_idle_domain_control;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, idle_exec = 0, bad;
  logic [15:0] addr = '0, wdata = '0;
  logic [9:0] dom_ack_async = '0;
  logic [13:0] per_ack_async = '0;
  wire [15:0] rdata_reg;
  wire [9:0] dom_stop_reg;
  wire [13:0] per_stop_reg;
  wire bus_error_reg;
  int err_total = 0, comparisons = 0, sel, dst, pst, i;
  integer seed = 32'hae87;
  always #10 clk = ~clk;
  idc_top dut(.*);
  task chk(input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %0t: %h vs %h", $time, s, e);
    end
  endtask
  task wreg(input logic [15:0] a, d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task rchk(input logic [15:0] a, e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata_reg, e);
  endtask
  // model: bad clock idle leaves stops alone
  task idle(input logic [15:0] c);
    wreg(16'h0001, c);
    bad = c[4] && (c & 16'h03F7) != 16'h03F7;
    @(posedge clk);
    idle_exec <= 1;
    @(posedge clk);
    idle_exec <= 0;
    if (!bad) begin
      dst = c & 16'h03FF;
      pst = c[3] ? sel : 0;
    end
    #1 chk(16'(bus_error_reg), 16'(bad));
    chk(16'(dom_stop_reg), dst[15:0]);
    chk(16'(per_stop_reg), pst[15:0]);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    conclude;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    rchk(16'h0001, 0);
    rchk(16'h1234, 0);
    wreg(16'h9400, 16'hFFFF);
    rchk(16'h9400, 16'h3FFF);
    wreg(16'h0002, 16'hFFFF);
    rchk(16'h0002, 0);
    wreg(16'h0001, 16'hFFFF);
    rchk(16'h0001, 16'h03FF);
    rchk(16'h9401, 0);
    $display("registers done");
    for (i = 0; i < 12; i++) begin
      sel = $random(seed) & 32'h3FFF;
      wreg(16'h9400, sel[15:0]);
      idle(16'($random(seed)) & 16'h03EF);
    end
    idle(16'h0008);
    idle(16'h0000);
    $display("idle done");
    idle(16'h0010);
    idle(16'h03FF);
    rchk(16'h0002, 0);
    @(posedge clk);
    dom_ack_async <= '1;
    per_ack_async <= '1;
    repeat (4) @(posedge clk);
    rchk(16'h0002, 16'h01FF);
    rchk(16'h9401, sel[15:0]);
    idle(16'h0000);
    repeat (4) @(posedge clk);
    rchk(16'h0002, 0);
    rchk(16'h9401, 0);
    $display("status done");
    conclude;
  end
endmodule
`default_nettype wire
